// ==== hdl/card_bus_pkg.sv ====
// Types shared by the card host bus decoder
package card_bus_pkg;
  typedef enum logic [4:0] {
    SP_IDLE   = 5'h01,
    SP_ATTR   = 5'h02,
    SP_COMMON = 5'h04,
    SP_IO     = 5'h08,
    SP_NATIVE = 5'h10
  } space_t;
  typedef enum logic [2:0] {
    LN_NONE = 3'h1,
    LN_LOW  = 3'h2,
    LN_BOTH = 3'h4
  } lane_t;
endpackage

// ==== hdl/card_bus_regs.svh ====
// Register offsets, field positions and reset values for the card host bus decoder
`ifndef CARD_BUS_REGS_SVH
`define CARD_BUS_REGS_SVH
`define CFG_BASE_ADDR       11'h200
`define SOCKET_COPY_OFFSET  11'h206
`define SOCKET_COPY_RESET   8'h00
`define DRIVE_SEL_BIT       4
`define TF_ALT_STATUS_ADDR  3'h6
`define TF_DRIVE_ADDR_ADDR  3'h7
`define TF_DATA_ADDR        3'h0
`define SET_FEAT_CMD        8'hEF
`define SET_FEAT_8BIT_ON    8'h01
`define SET_FEAT_8BIT_OFF   8'h81
`define TF_CMD_ADDR         3'h7
`define TF_FEAT_ADDR        3'h1
`endif

// ==== hdl/card_host_bus_access_decode.sv ====
// Host bus access decoder: attribute, common memory, I/O and native disk spaces
// Operation
// - Drive select bit D4 read/write
// - Socket number ignored, D3-D0 read zero
// - Configuration registers at attribute base 200h
// - Attribute space ignored in native disk mode
// - Attribute read drives only even byte
// - Card information structure is read only
// - Word attribute access: only low lane valid
// - All I/O space ports flagged sixteen bit capable; in native mode only the data port and DMA, when not in 8-bit mode
// - Byte lane steering by enables and A0
// - Common memory byte and word access decoded
// - Native mode only if read strobe grounded
// - Native mode: only task file, control block (alternate status, drive address) and DMA I/O
// - Set-features switches native transfers to 8-bit
// - Reinsertion comes up in socket mode if read strobe high
`timescale 1ns/1ps
`include "card_bus_regs.svh"
module card_host_bus_access_decode
  import card_bus_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  // Card detect: low while seated in socket
  input  wire logic        CARD_SEATED_N,
  // Host address and enables
  input  wire logic [10:0] ADDR,
  input  wire logic        LOW_LANE_ENABLE_N,
  input  wire logic        HIGH_LANE_ENABLE_N,
  input  wire logic        ATTR_SELECT_N,
  // Host strobes
  input  wire logic        MEM_READ_STROBE_N,
  input  wire logic        MEM_WRITE_STROBE_N,
  input  wire logic        IO_READ_STROBE_N,
  input  wire logic        IO_WRITE_STROBE_N,
  // Native disk selects
  input  wire logic        TASK_SELECT_N,
  input  wire logic        CONTROL_SELECT_N,
  input  wire logic        DMA_ACKNOWLEDGE_N,
  // Data bus, split into in, out and enables per lane
  input  wire logic [15:0] DATA_IN,
  output logic      [15:0] DATA_OUT,
  output logic             DATA_LOW_OE,
  output logic             DATA_HIGH_OE,
  // Port width indicator
  output logic             WIDE_PORT_INDICATOR_N,
  // Core side: register window
  output logic             CORE_WR_STB,
  output logic             CORE_RD_STB,
  output logic      [3:0]  CORE_REG_ADDR,
  output logic      [15:0] CORE_WR_DATA,
  output logic             CORE_WIDE,
  output logic             CORE_INVALID,
  input  wire logic [15:0] CORE_RD_DATA,
  input  wire logic [7:0]  CIS_RD_DATA,
  // Mode status
  output logic             NATIVE_DISK_MODE,
  output logic             NATIVE_BYTE_MODE,
  output logic      [7:0]  SOCKET_COPY_CONFIG
);
  // Synchronised pins, order fixed below
  logic [11:0] pins_s;
  logic [10:0] addr_q;
  logic [10:0] addr_s;
  logic [15:0] din_q;
  logic [15:0] din_s;

  pin_sync #(.WIDTH(12)) u_pins (
    .clk     (CORE_CLK),
    .rst     (RESET),
    .pin_in  ({CARD_SEATED_N, LOW_LANE_ENABLE_N, HIGH_LANE_ENABLE_N, ATTR_SELECT_N,
               MEM_READ_STROBE_N, MEM_WRITE_STROBE_N, IO_READ_STROBE_N, IO_WRITE_STROBE_N,
               TASK_SELECT_N, CONTROL_SELECT_N, DMA_ACKNOWLEDGE_N, 1'b1}),
    .pin_out (pins_s)
  );

  // Address and data also pass two flops; stable while strobes are held
  always_ff @(posedge CORE_CLK) begin
    addr_q <= ADDR;
    addr_s <= addr_q;
    din_q  <= DATA_IN;
    din_s  <= din_q;
  end

  wire seated_n = pins_s[11];
  wire ce1_n    = pins_s[10];
  wire ce2_n    = pins_s[9];
  wire attr_n   = pins_s[8];
  wire mrd_n    = pins_s[7];
  wire mwr_n    = pins_s[6];
  wire io_read_strobe_n_n   = pins_s[5];
  wire io_write_strobe_n_n   = pins_s[4];
  wire tsel_n   = pins_s[3];
  wire csel_n   = pins_s[2];
  wire dack_n   = pins_s[1];

  // Mode and register state
  logic        native_q;
  logic        byte8_q;
  logic        seated_q;
  logic [7:0]  sock_q;
  logic        busy_q;
  logic [1:0]  byte8_feat_q;
  space_t      space_d;

  // Lane selection used by every space except attribute space
  function automatic lane_t lane_of(input logic c1n, input logic c2n);
    if (!c1n && !c2n)
      lane_of = LN_BOTH;
    else if (!c1n)
      lane_of = LN_LOW;
    else
      lane_of = LN_NONE;
  endfunction

  // Decoded cycle attributes
  wire   any_mem   = !mrd_n || !mwr_n;
  wire   any_io    = !io_read_strobe_n_n || !io_write_strobe_n_n;
  wire   enabled   = !ce1_n || !ce2_n;
  wire   rd_cyc    = !mrd_n || !io_read_strobe_n_n;
  wire   attr_hit  = !native_q && enabled && !attr_n && any_mem;
  wire   attr_rd   = attr_hit && !mrd_n && mwr_n;
  wire   cfg_hit   = attr_hit && addr_s[9] && !addr_s[10];
  wire   sock_hit  = cfg_hit && (addr_s == `SOCKET_COPY_OFFSET);
  wire   cis_hit   = attr_hit && !addr_s[9] && !addr_s[10];
  wire   common_hit = !native_q && enabled && attr_n && any_mem;
  // I/O cycles need attribute select low; with it high the strobe is inhibited
  wire   io_hit    = !native_q && enabled && !attr_n && any_io;
  wire   dma_bad   = !dack_n && (!tsel_n || !csel_n);
  wire   nat_task  = native_q && !tsel_n && csel_n && dack_n && any_io;
  wire   nat_ctrl  = native_q && tsel_n && !csel_n && dack_n && any_io &&
                     (addr_s[2:0] == `TF_ALT_STATUS_ADDR ||
                      (addr_s[2:0] == `TF_DRIVE_ADDR_ADDR && !io_read_strobe_n_n));
  wire   nat_dma   = native_q && !dack_n && tsel_n && csel_n && any_io;
  wire   nat_hit   = nat_task || nat_ctrl || nat_dma;
  lane_t lane;
  assign lane      = lane_of(ce1_n, ce2_n);
  wire   odd_only  = ce1_n && !ce2_n;
  wire   nat_wide  = (nat_dma || (nat_task && addr_s[2:0] == `TF_DATA_ADDR)) && !byte8_q;

  // Space of the current cycle
  always_comb begin
    if (nat_hit)
      space_d = SP_NATIVE;
    else if (attr_hit)
      space_d = SP_ATTR;
    else if (common_hit)
      space_d = SP_COMMON;
    else if (io_hit)
      space_d = SP_IO;
    else
      space_d = SP_IDLE;
  end

  // Lane steering for I/O and common memory reads
  logic [15:0] steer_rd;
  always_comb begin
    case (lane)
      LN_BOTH: steer_rd = CORE_RD_DATA;
      LN_LOW:  steer_rd = {8'h00, (addr_s[0] ? CORE_RD_DATA[15:8] : CORE_RD_DATA[7:0])};
      default: steer_rd = {CORE_RD_DATA[15:8], 8'h00};
    endcase
  end

  // Attribute reads put one byte on the low lane only
  wire [7:0]  sock_rd  = {1'b0, 2'b00, sock_q[`DRIVE_SEL_BIT], 4'h0};
  wire [7:0]  attr_byte = sock_hit ? sock_rd : (cis_hit ? CIS_RD_DATA : CORE_RD_DATA[7:0]);
  wire [15:0] rd_word  = (space_d == SP_ATTR) ? {8'h00, attr_byte} :
                         (space_d == SP_NATIVE) ? (nat_wide ? CORE_RD_DATA : {8'h00, CORE_RD_DATA[7:0]}) :
                         steer_rd;
  wire        drive_lo = rd_cyc && ((space_d == SP_ATTR && attr_rd) ||
                         ((space_d == SP_COMMON || space_d == SP_IO) && !ce1_n) ||
                         space_d == SP_NATIVE);
  wire        drive_hi = rd_cyc && (((space_d == SP_COMMON || space_d == SP_IO) && !ce2_n) ||
                         (space_d == SP_NATIVE && nat_wide));

  // Write data lane packing toward the core
  wire [15:0] wr_word = odd_only ? {din_s[15:8], din_s[15:8]} :
                        (lane == LN_LOW && addr_s[0]) ? {din_s[7:0], din_s[7:0]} : din_s;
  wire        write_now = !mwr_n || !io_write_strobe_n_n;
  wire        start   = (space_d != SP_IDLE) && !busy_q;
  wire        core_wr = start && write_now && (space_d != SP_ATTR);
  wire        core_rd = start && rd_cyc && space_d != SP_ATTR;
  wire [3:0]  reg_idx = (space_d == SP_COMMON && addr_s[10]) ? {3'b100, addr_s[0]} : addr_s[3:0];

  // Cycle tracking: one core strobe per strobe assertion
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      busy_q  <= 1'b0;
    end else begin
      busy_q  <= (space_d != SP_IDLE);
    end
  end

  // Socket and copy register; writes to the information structure fall through
  always_ff @(posedge CORE_CLK) begin
    if (RESET || !seated_q) begin
      sock_q <= `SOCKET_COPY_RESET;
    end else if (start && sock_hit && !mwr_n && !ce1_n && !addr_s[0]) begin
      sock_q <= {3'b000, din_s[`DRIVE_SEL_BIT], 4'h0};
    end
  end

  // Mode strap caught on card seating; reinsertion reloads it
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      seated_q <= 1'b0;
      native_q <= 1'b0;
      byte8_q  <= 1'b0;
    end else begin
      seated_q <= !seated_n;
      if (!seated_n && !seated_q)
        native_q <= !mrd_n;
      else if (seated_n)
        native_q <= 1'b0;
      if (!native_q)
        byte8_q <= 1'b0;
      else if (start && nat_task && !io_write_strobe_n_n && addr_s[2:0] == `TF_CMD_ADDR &&
               din_s[7:0] == `SET_FEAT_CMD && byte8_feat_q != 2'b00)
        byte8_q <= (byte8_feat_q == 2'b01);
    end
  end

  // Last feature code, so the command can pick the width
  always_ff @(posedge CORE_CLK) begin
    if (RESET || !native_q)
      byte8_feat_q <= 2'b00;
    else if (start && nat_task && !io_write_strobe_n_n && addr_s[2:0] == `TF_FEAT_ADDR)
      byte8_feat_q <= (din_s[7:0] == `SET_FEAT_8BIT_ON) ? 2'b01 :
                      (din_s[7:0] == `SET_FEAT_8BIT_OFF) ? 2'b10 : 2'b00;
  end

  // Registered pin and core outputs
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      DATA_OUT              <= 16'h0000;
      DATA_LOW_OE           <= 1'b0;
      DATA_HIGH_OE          <= 1'b0;
      WIDE_PORT_INDICATOR_N <= 1'b1;
      CORE_WR_STB           <= 1'b0;
      CORE_RD_STB           <= 1'b0;
      CORE_REG_ADDR         <= 4'h0;
      CORE_WR_DATA          <= 16'h0000;
      CORE_WIDE             <= 1'b0;
      CORE_INVALID          <= 1'b0;
    end else begin
      DATA_OUT              <= rd_word;
      DATA_LOW_OE           <= drive_lo;
      DATA_HIGH_OE          <= drive_hi;
      WIDE_PORT_INDICATOR_N <= !(io_hit || (nat_hit && nat_wide));
      CORE_WR_STB           <= core_wr;
      CORE_RD_STB           <= core_rd;
      CORE_REG_ADDR         <= reg_idx;
      CORE_WR_DATA          <= wr_word;
      CORE_WIDE             <= (space_d == SP_NATIVE) ? nat_wide : (lane == LN_BOTH);
      CORE_INVALID          <= native_q && dma_bad;
    end
  end

  assign NATIVE_DISK_MODE   = native_q;
  assign NATIVE_BYTE_MODE   = byte8_q;
  assign SOCKET_COPY_CONFIG = sock_q;
endmodule // card_host_bus_access_decode

// ==== hdl/pin_sync.sv ====
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Pins in, synchronised out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second; idle level high for strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q  <= {WIDTH{1'b1}};
      pin_out <= {WIDTH{1'b1}};
    end else begin
      meta_q  <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule // pin_sync

// ==== verification/card_bus_sva.sv ====
// Concurrent checks on the card host bus decoder ports
`timescale 1ns/1ps
module card_bus_sva (
  // Clock, reset and card detect
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  input wire logic        CARD_SEATED_N,
  // Host pins
  input wire logic [10:0] ADDR,
  input wire logic        LOW_LANE_ENABLE_N,
  input wire logic        ATTR_SELECT_N,
  input wire logic        MEM_READ_STROBE_N,
  input wire logic        MEM_WRITE_STROBE_N,
  input wire logic        IO_READ_STROBE_N,
  input wire logic        IO_WRITE_STROBE_N,
  input wire logic        TASK_SELECT_N,
  input wire logic        DMA_ACKNOWLEDGE_N,
  input wire logic [15:0] DATA_IN,
  // Design outputs
  input wire logic        DATA_LOW_OE,
  input wire logic        DATA_HIGH_OE,
  input wire logic        WIDE_PORT_INDICATOR_N,
  input wire logic        CORE_WR_STB,
  input wire logic        CORE_RD_STB,
  input wire logic        CORE_INVALID,
  input wire logic        NATIVE_DISK_MODE,
  input wire logic [7:0]  SOCKET_COPY_CONFIG
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // Held cycles; several samples so the pin synchronisers have settled
  sequence attr_rd; (!ATTR_SELECT_N && !MEM_READ_STROBE_N && MEM_WRITE_STROBE_N && !NATIVE_DISK_MODE) [*6]; endsequence
  sequence io_rd; (!ATTR_SELECT_N && !IO_READ_STROBE_N && !LOW_LANE_ENABLE_N && !NATIVE_DISK_MODE) [*5]; endsequence
  sequence io_off; (ATTR_SELECT_N && !IO_READ_STROBE_N && MEM_READ_STROBE_N && !NATIVE_DISK_MODE) [*6]; endsequence
  sequence sock_wr; (!ATTR_SELECT_N && !MEM_WRITE_STROBE_N && !LOW_LANE_ENABLE_N && ADDR == 11'h206
    && !NATIVE_DISK_MODE) [*5]; endsequence
  sequence bad_dma; (NATIVE_DISK_MODE && !DMA_ACKNOWLEDGE_N && !TASK_SELECT_N && !IO_READ_STROBE_N) [*5]; endsequence
  sock_drive_a: assert property (sock_wr |-> SOCKET_COPY_CONFIG == {3'h0, DATA_IN[4], 4'h0})
    else $error("socket register value wrong");
  sock_zero_a: assert property (SOCKET_COPY_CONFIG[7:5] == 3'h0 && SOCKET_COPY_CONFIG[3:0] == 4'h0)
    else $error("socket register spare bits set");
  attr_lane_a: assert property (attr_rd |-> !DATA_HIGH_OE) else $error("attribute read drives high lane");
  wide_io_a: assert property (io_rd |-> !WIDE_PORT_INDICATOR_N) else $error("wide indicator missing");
  io_inhibit_a: assert property (io_off |-> !DATA_LOW_OE && !DATA_HIGH_OE) else $error("inhibited read drives");
  native_attr_a: assert property (NATIVE_DISK_MODE && $past(NATIVE_DISK_MODE) && !CARD_SEATED_N
    && $past(CARD_SEATED_N, 3) == 1'b0 |-> $stable(SOCKET_COPY_CONFIG)) else $error("socket changed natively");
  dma_invalid_a: assert property (bad_dma |-> CORE_INVALID) else $error("dma with select not flagged");
  write_cause_a: assert property (CORE_WR_STB |-> ($past(MEM_WRITE_STROBE_N, 2) == 1'b0
    || $past(IO_WRITE_STROBE_N, 2) == 1'b0) ##1 !CORE_WR_STB) else $error("stray core write");
  read_pulse_a: assert property (CORE_RD_STB |=> !CORE_RD_STB) else $error("core read not one cycle");
  reset_state_a: assert property ($fell(RESET) |-> SOCKET_COPY_CONFIG == 8'h00 && WIDE_PORT_INDICATOR_N
    && !NATIVE_DISK_MODE) else $error("wrong state after reset");
endmodule // card_bus_sva
bind card_host_bus_access_decode card_bus_sva card_bus_sva_i (.CORE_CLK(CORE_CLK), .RESET(RESET),
  .CARD_SEATED_N(CARD_SEATED_N), .ADDR(ADDR), .LOW_LANE_ENABLE_N(LOW_LANE_ENABLE_N), .ATTR_SELECT_N(ATTR_SELECT_N),
  .MEM_READ_STROBE_N(MEM_READ_STROBE_N), .MEM_WRITE_STROBE_N(MEM_WRITE_STROBE_N),
  .IO_READ_STROBE_N(IO_READ_STROBE_N), .IO_WRITE_STROBE_N(IO_WRITE_STROBE_N), .TASK_SELECT_N(TASK_SELECT_N),
  .DMA_ACKNOWLEDGE_N(DMA_ACKNOWLEDGE_N), .DATA_IN(DATA_IN), .DATA_LOW_OE(DATA_LOW_OE), .DATA_HIGH_OE(DATA_HIGH_OE),
  .WIDE_PORT_INDICATOR_N(WIDE_PORT_INDICATOR_N), .CORE_WR_STB(CORE_WR_STB), .CORE_RD_STB(CORE_RD_STB),
  .CORE_INVALID(CORE_INVALID), .NATIVE_DISK_MODE(NATIVE_DISK_MODE), .SOCKET_COPY_CONFIG(SOCKET_COPY_CONFIG));

// ==== verification/card_host_bus_access_decode_bench.sv ====
// Self-checking bench for the card host bus decoder
`timescale 1ns/1ps
module card_host_bus_access_decode_bench;
  logic        clk, rst, seat_n, attr_n, ts_n, cs_n, dack_n, loe, hoe, wide_n, inv, nat, byt;
  logic [1:0]  ens;
  logic [3:0]  stb;
  logic [10:0] addr;
  logic [15:0] din, dout, pat, rdat, d;
  logic [7:0]  card_info_structure, scc;
  logic [17:0] e;
  logic        wr_stb, rd_stb, cwide, cw;
  logic [3:0]  radr, cadr;
  logic [15:0] wdat, cdat;
  logic [7:0]  n_wr = 8'h00;
  logic [7:0]  n_rd = 8'h00;
  int          fail_count = 0, n_compared = 0, cyc = 0, i, j, k;
  card_host_bus_access_decode card_host_bus_access_decode_i (.CORE_CLK(clk), .RESET(rst), .CARD_SEATED_N(seat_n),
    .ADDR(addr), .LOW_LANE_ENABLE_N(ens[0]), .HIGH_LANE_ENABLE_N(ens[1]), .ATTR_SELECT_N(attr_n),
    .MEM_READ_STROBE_N(stb[0]), .MEM_WRITE_STROBE_N(stb[1]), .IO_READ_STROBE_N(stb[2]), .IO_WRITE_STROBE_N(stb[3]),
    .TASK_SELECT_N(ts_n), .CONTROL_SELECT_N(cs_n), .DMA_ACKNOWLEDGE_N(dack_n), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_LOW_OE(loe), .DATA_HIGH_OE(hoe), .WIDE_PORT_INDICATOR_N(wide_n), .CORE_WR_STB(wr_stb),
    .CORE_RD_STB(rd_stb), .CORE_REG_ADDR(radr), .CORE_WR_DATA(wdat), .CORE_WIDE(cwide), .CORE_INVALID(inv),
    .CORE_RD_DATA(rdat), .CIS_RD_DATA(card_info_structure),
    .NATIVE_DISK_MODE(nat), .NATIVE_BYTE_MODE(byt), .SOCKET_COPY_CONFIG(scc));
  core_model core_model_i (.pat(pat), .rd_data(rdat), .cis_data(card_info_structure));
  // Core strobes stand one cycle, so the falling edge sees each pulse once
  always @(negedge clk) begin
    if (wr_stb) begin
      n_wr++;
      cadr = radr;
      cdat = wdat;
      cw = cwide;
    end
    if (rd_stb) begin
      n_rd++;
    end
  end
  // Clock and hang guard; the whole run needs well under 2000 cycles
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // Expected lane enables and data: 0 word, 1 low even, 2 low odd, 3 high only
  function automatic logic [17:0] lane(input int m, input logic [15:0] w);
    case (m)
      0: return {2'b11, w};
      1: return {2'b01, 8'h00, w[7:0]};
      2: return {2'b01, 8'h00, w[15:8]};
      default: return {2'b10, w[15:8], 8'h00};
    endcase
  endfunction
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Hold a strobe long enough for the synchronised answer, leave it held for sampling
  task automatic go(input logic [10:0] a, input logic r, input int s, input logic [1:0] ce, input logic [15:0] w);
    @(negedge clk);
    addr = a;
    attr_n = r;
    ens = ce;
    din = w;
    stb[s] = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  // Negate strobes and enables, then keep the bus idle between cycles
  task automatic rel();
    stb = 4'hF;
    ens = 2'b11;
    repeat (8) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {rst, seat_n, attr_n, ts_n, cs_n, dack_n, ens, stb} = 12'hFFF;
    addr = 11'h000;
    din = 16'h0000;
    pat = 16'h0000;
    void'($urandom(32'h21B2));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    seat_n = 1'b0;
    repeat (5) @(negedge clk);
    chk({wide_n, scc}, 9'h100);
    // Socket register: drive select kept, socket number dropped, byte reads only
    for (i = 0; i < 6; i++) begin
      d = (i == 0) ? 16'hFFFF : 16'($urandom);
      go(11'h206, 1'b0, 1, 2'b10, d);
      chk(scc, {3'h0, d[4], 4'h0});
      rel();
      go(11'h206, 1'b0, 0, 2'b00, 16'h0000);
      chk({hoe, loe, dout[7:0]}, {2'b01, 3'h0, d[4], 4'h0});
      rel();
    end
    // Card information space is read only
    pat = 16'($urandom);
    go(11'h004, 1'b0, 1, 2'b10, 16'h00FF);
    chk(scc, {3'h0, d[4], 4'h0});
    chk(n_wr, 8'h00);
    rel();
    go(11'h004, 1'b0, 0, 2'b10, 16'h0000);
    chk(dout[7:0], pat[15:8] ^ 8'h3C);
    rel();
    // Lane steering in I/O space, then common memory
    for (k = 0; k < 8; k++) begin
      j = k % 4;
      pat = 16'($urandom);
      e = lane(j, pat);
      go({10'($urandom), j == 2}, k > 3, k > 3 ? 0 : 2, j == 0 ? 2'b00 : j == 3 ? 2'b01 : 2'b10, 16'h0000);
      chk({hoe, loe, dout & {{8{e[17]}}, {8{e[16]}}}}, e);
      if (k < 4) chk(wide_n, 1'b0);
      rel();
    end
    // Core writes: a word into the data window, then an odd I/O byte on the low lane
    d = 16'($urandom);
    go(11'h400, 1'b1, 1, 2'b00, d);
    chk({cadr, cw}, {4'h8, 1'b1});
    chk(cdat, d);
    chk(n_wr, 8'h01);
    rel();
    go(11'h011, 1'b0, 3, 2'b10, d);
    chk({cadr, cdat[15:8], cw}, {4'h1, d[7:0], 1'b0});
    chk(n_wr, 8'h02);
    rel();
    go(11'h010, 1'b1, 2, 2'b00, 16'h0000);
    chk({hoe, loe}, 2'b00);
    chk(n_rd, 8'h08);
    rel();
    // Native disk mode: read strobe grounded across seating
    seat_n = 1'b1;
    stb[0] = 1'b0;
    repeat (6) @(negedge clk);
    seat_n = 1'b0;
    repeat (6) @(negedge clk);
    stb[0] = 1'b1;
    repeat (6) @(negedge clk);
    chk(nat, 1'b1);
    go(11'h206, 1'b0, 1, 2'b10, 16'hFFFF);
    chk(scc, 8'h00);
    chk(n_wr, 8'h02);
    rel();
    ts_n = 1'b0;
    for (i = 0; i < 2; i++) begin
      go(11'h001, 1'b1, 3, 2'b11, i == 0 ? 16'h0001 : 16'h0081);
      rel();
      go(11'h007, 1'b1, 3, 2'b11, 16'h00EF);
      rel();
      chk(byt, i == 0);
      // Data read: byte mode drops the indicator, so the host splits words
      go(11'h000, 1'b1, 2, 2'b11, 16'h0000);
      chk({hoe, loe, wide_n}, i == 0 ? 3'b011 : 3'b110);
      rel();
    end
    chk({n_wr, cadr}, {8'h06, 4'h7});
    go(11'h000, 1'b1, 2, 2'b11, 16'h0000);
    chk({hoe, loe, wide_n}, 3'b110);
    chk(dout, pat);
    rel();
    dack_n = 1'b0;
    go(11'h000, 1'b1, 2, 2'b11, 16'h0000);
    chk(inv, 1'b1);
    rel();
    {ts_n, cs_n, dack_n} = 3'b101;
    go(11'h006, 1'b1, 2, 2'b11, 16'h0000);
    chk({hoe, loe}, 2'b01);
    rel();
    // DMA data word with both selects negated
    {ts_n, cs_n, dack_n} = 3'b110;
    go(11'h000, 1'b1, 2, 2'b11, 16'h0000);
    chk({hoe, loe, wide_n, inv}, 4'b1100);
    chk(dout, pat);
    rel();
    dack_n = 1'b1;
    // Reinsertion with the read strobe high returns to socket mode
    seat_n = 1'b1;
    repeat (6) @(negedge clk);
    seat_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(nat, 1'b0);
    tally_and_finish();
  end
endmodule // card_host_bus_access_decode_bench

// ==== verification/core_model.sv ====
// Core side model returning register and card information data
`timescale 1ns/1ps
module core_model (
  // Pattern chosen by the bench
  input  wire logic [15:0] pat,
  // Read data towards the decoder
  output logic      [15:0] rd_data,
  output logic      [7:0]  cis_data
);
  // Fixed content, never written by the host side
  assign rd_data  = pat;
  assign cis_data = pat[15:8] ^ 8'h3C;
endmodule // core_model
